// *** pkg/i2c_coll_pkg.sv ***
package i2c_coll_pkg;

    // width of the baud reload field and of the bit rate counter
    localparam int RELOAD_W = 7;
    // top bit of the baud reload field inside the reload byte
    localparam int RELOAD_MSB = 6;
    // width of the whole baud reload value port
    localparam int RELOAD_BYTE_W = 8;

    // reset values and counter constants
    localparam logic [RELOAD_W-1:0] CNT_RESET = 7'h00;
    localparam logic [RELOAD_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [RELOAD_W-1:0] CNT_ONE = 7'h01;
    // released open-drain lines idle high
    localparam logic LINE_IDLE = 1'b1;
    localparam logic OE_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;

    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        RS_REL_SDA  = 4'b0001,
        RS_CNT1     = 4'b0010,
        RS_SCL_WAIT = 4'b0011,
        RS_CNT2     = 4'b0100,
        RS_CNT3     = 4'b0101,
        SP_SDA_LOW  = 4'b0110,
        SP_SCL_WAIT = 4'b0111,
        SP_CNT1     = 4'b1000,
        SP_CNT2     = 4'b1001
    } seq_state_t;

endpackage

// *** pkg/line_level_if.sv ***
`timescale 1ns/1ps
// synchronised bus line levels, handed from the sampler to the sequencer
interface line_level_if;
    logic sda_level;
    logic scl_level;

    modport sampler (
        output sda_level,
        output scl_level
    );

    modport core (
        input sda_level,
        input scl_level
    );
endinterface

// *** core/line_sampler.sv ***
`timescale 1ns/1ps
module line_sampler (
    // clocks and reset
    input wire logic clk_sys_in,
    input wire logic clk_link_in,
    input wire logic rst_in,
    // raw pin levels
    input wire logic sda_pin_in,
    input wire logic scl_pin_in,
    // synchronised levels in the system domain
    line_level_if.sampler lines
);

    logic sda_link_meta_reg;
    logic sda_link_reg;
    logic scl_link_meta_reg;
    logic scl_link_reg;
    logic sda_sys_meta_reg;
    logic sda_sys_reg;
    logic scl_sys_meta_reg;
    logic scl_sys_reg;

    // pins are asynchronous: two flops on the link clock first
    always_ff @(posedge clk_link_in or posedge rst_in) begin
        if (rst_in) begin
            sda_link_meta_reg <= i2c_coll_pkg::LINE_IDLE;
            sda_link_reg <= i2c_coll_pkg::LINE_IDLE;
            scl_link_meta_reg <= i2c_coll_pkg::LINE_IDLE;
            scl_link_reg <= i2c_coll_pkg::LINE_IDLE;
        end else begin
            sda_link_meta_reg <= sda_pin_in;
            sda_link_reg <= sda_link_meta_reg;
            scl_link_meta_reg <= scl_pin_in;
            scl_link_reg <= scl_link_meta_reg;
        end
    end

    // levels cross into the system domain through two more flops
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sda_sys_meta_reg <= i2c_coll_pkg::LINE_IDLE;
            sda_sys_reg <= i2c_coll_pkg::LINE_IDLE;
            scl_sys_meta_reg <= i2c_coll_pkg::LINE_IDLE;
            scl_sys_reg <= i2c_coll_pkg::LINE_IDLE;
        end else begin
            sda_sys_meta_reg <= sda_link_reg;
            sda_sys_reg <= sda_sys_meta_reg;
            scl_sys_meta_reg <= scl_link_reg;
            scl_sys_reg <= scl_sys_meta_reg;
        end
    end

    // only the second system flop is ever looked at
    assign lines.sda_level = sda_sys_reg;
    assign lines.scl_level = scl_sys_reg;

endmodule // line_sampler

// *** core/i2c_rsen_stop_master.sv ***
`timescale 1ns/1ps
module i2c_rsen_stop_master #(
    parameter int RELOAD_W = i2c_coll_pkg::RELOAD_W
) (
    // system clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // pin sampling clock
    input wire logic LINK_CLK_IN,
    // serial data pin
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // serial clock pin
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    // sequence requests and timing
    input wire logic RSTART_REQ_IN,
    input wire logic STOP_REQ_IN,
    input wire logic [i2c_coll_pkg::RELOAD_BYTE_W-1:0] BAUD_RELOAD_VALUE_IN,
    // master_sequence_control bits and status
    output logic RSTART_ACTIVE_OUT,
    output logic STOP_ACTIVE_OUT,
    output logic SEQ_DONE_OUT,
    // collision_irq_flag, sticky until cleared
    output logic COLLISION_IRQ_FLAG_OUT,
    input wire logic COLLISION_CLEAR_IN
);

    line_level_if lines ();

    i2c_coll_pkg::seq_state_t state_reg;
    i2c_coll_pkg::seq_state_t state_next;
    logic [RELOAD_W-1:0] bit_rate_counter_reg;
    logic [RELOAD_W-1:0] bit_rate_counter_next;
    logic [RELOAD_W-1:0] reload;
    logic sda_oe_reg;
    logic sda_oe_next;
    logic scl_oe_reg;
    logic scl_oe_next;
    logic rstart_bit_reg;
    logic rstart_bit_next;
    logic stop_bit_reg;
    logic stop_bit_next;
    logic done_reg;
    logic done_next;
    logic flag_reg;
    logic flag_next;
    logic coll_set;
    logic expired;
    logic sda_s;
    logic scl_s;

    // two flops per domain stand between each pin and the sequencer
    line_sampler u_sampler (
        .clk_sys_in(CLK_IN),
        .clk_link_in(LINK_CLK_IN),
        .rst_in(RST_IN),
        .sda_pin_in(SDA_IN),
        .scl_pin_in(SCL_IN),
        .lines(lines.sampler)
    );

    // every decision below reads the bus lines only through these samples
    assign sda_s = lines.sda_level;
    assign scl_s = lines.scl_level;
    assign reload = BAUD_RELOAD_VALUE_IN[i2c_coll_pkg::RELOAD_MSB:0];
    assign expired = (bit_rate_counter_reg == i2c_coll_pkg::CNT_ZERO);

    // sequencer: counts only in count states, so waits suspend it
    always_comb begin
        state_next = state_reg;
        bit_rate_counter_next = bit_rate_counter_reg;
        sda_oe_next = sda_oe_reg;
        scl_oe_next = scl_oe_reg;
        rstart_bit_next = rstart_bit_reg;
        stop_bit_next = stop_bit_reg;
        done_next = 1'b0;
        coll_set = 1'b0;
        unique case (state_reg)
            i2c_coll_pkg::ST_IDLE: begin
                // repeated start wins when both are asked at once
                if (RSTART_REQ_IN) begin
                    rstart_bit_next = 1'b1;
                    sda_oe_next = 1'b0;
                    scl_oe_next = 1'b1;
                    state_next = i2c_coll_pkg::RS_REL_SDA;
                end else if (STOP_REQ_IN) begin
                    stop_bit_next = 1'b1;
                    sda_oe_next = 1'b1;
                    scl_oe_next = 1'b1;
                    state_next = i2c_coll_pkg::SP_SDA_LOW;
                end
            end
            i2c_coll_pkg::RS_REL_SDA: begin
                if (sda_s) begin
                    bit_rate_counter_next = reload;
                    state_next = i2c_coll_pkg::RS_CNT1;
                end
            end
            i2c_coll_pkg::RS_CNT1: begin
                if (expired) begin
                    scl_oe_next = 1'b0;
                    state_next = i2c_coll_pkg::RS_SCL_WAIT;
                end else begin
                    bit_rate_counter_next = bit_rate_counter_reg
                        - i2c_coll_pkg::CNT_ONE;
                end
            end
            i2c_coll_pkg::RS_SCL_WAIT: begin
                // clock arbitration: nothing happens until SCL is high
                if (scl_s) begin
                    if (!sda_s) begin
                        coll_set = 1'b1;
                    end else begin
                        bit_rate_counter_next = reload;
                        state_next = i2c_coll_pkg::RS_CNT2;
                    end
                end
            end
            i2c_coll_pkg::RS_CNT2: begin
                if (!sda_s) begin
                    // another master started first: join it early
                    sda_oe_next = 1'b1;
                    bit_rate_counter_next = reload;
                    state_next = i2c_coll_pkg::RS_CNT3;
                end else if (!scl_s) begin
                    coll_set = 1'b1;
                end else if (expired) begin
                    sda_oe_next = 1'b1;
                    bit_rate_counter_next = reload;
                    state_next = i2c_coll_pkg::RS_CNT3;
                end else begin
                    bit_rate_counter_next = bit_rate_counter_reg
                        - i2c_coll_pkg::CNT_ONE;
                end
            end
            i2c_coll_pkg::RS_CNT3: begin
                // SCL is driven low whatever its level now
                if (expired) begin
                    scl_oe_next = 1'b1;
                    rstart_bit_next = 1'b0;
                    done_next = 1'b1;
                    state_next = i2c_coll_pkg::ST_IDLE;
                end else begin
                    bit_rate_counter_next = bit_rate_counter_reg
                        - i2c_coll_pkg::CNT_ONE;
                end
            end
            i2c_coll_pkg::SP_SDA_LOW: begin
                if (!sda_s) begin
                    scl_oe_next = 1'b0;
                    state_next = i2c_coll_pkg::SP_SCL_WAIT;
                end
            end
            i2c_coll_pkg::SP_SCL_WAIT: begin
                if (scl_s) begin
                    bit_rate_counter_next = reload;
                    state_next = i2c_coll_pkg::SP_CNT1;
                end
            end
            i2c_coll_pkg::SP_CNT1: begin
                if (!scl_s) begin
                    coll_set = 1'b1;
                end else if (expired) begin
                    sda_oe_next = 1'b0;
                    bit_rate_counter_next = reload;
                    state_next = i2c_coll_pkg::SP_CNT2;
                end else begin
                    bit_rate_counter_next = bit_rate_counter_reg
                        - i2c_coll_pkg::CNT_ONE;
                end
            end
            i2c_coll_pkg::SP_CNT2: begin
                if (!scl_s && !sda_s) begin
                    coll_set = 1'b1;
                end else if (expired) begin
                    if (!sda_s) begin
                        coll_set = 1'b1;
                    end else begin
                        stop_bit_next = 1'b0;
                        done_next = 1'b1;
                        state_next = i2c_coll_pkg::ST_IDLE;
                    end
                end else begin
                    bit_rate_counter_next = bit_rate_counter_reg
                        - i2c_coll_pkg::CNT_ONE;
                end
            end
            default: begin
                // unused codes fall back to a released, idle bus
                sda_oe_next = 1'b0;
                scl_oe_next = 1'b0;
                state_next = i2c_coll_pkg::ST_IDLE;
            end
        endcase
        // abort: free both lines and drop the sequence bits
        if (coll_set) begin
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
            rstart_bit_next = 1'b0;
            stop_bit_next = 1'b0;
            state_next = i2c_coll_pkg::ST_IDLE;
        end
        // a new collision beats a clear in the same cycle
        flag_next = coll_set | (flag_reg & ~COLLISION_CLEAR_IN);
    end

    // state registers
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= i2c_coll_pkg::ST_IDLE;
            bit_rate_counter_reg <= i2c_coll_pkg::CNT_RESET;
            sda_oe_reg <= i2c_coll_pkg::OE_RESET;
            scl_oe_reg <= i2c_coll_pkg::OE_RESET;
            rstart_bit_reg <= 1'b0;
            stop_bit_reg <= 1'b0;
            done_reg <= 1'b0;
            flag_reg <= i2c_coll_pkg::FLAG_RESET;
        end else begin
            state_reg <= state_next;
            bit_rate_counter_reg <= bit_rate_counter_next;
            sda_oe_reg <= sda_oe_next;
            scl_oe_reg <= scl_oe_next;
            rstart_bit_reg <= rstart_bit_next;
            stop_bit_reg <= stop_bit_next;
            done_reg <= done_next;
            flag_reg <= flag_next;
        end
    end

    // open drain: the pad only ever pulls low
    assign SDA_OUT = 1'b0;
    assign SCL_OUT = 1'b0;
    assign SDA_OE_OUT = sda_oe_reg;
    assign SCL_OE_OUT = scl_oe_reg;
    assign RSTART_ACTIVE_OUT = rstart_bit_reg;
    assign STOP_ACTIVE_OUT = stop_bit_reg;
    assign SEQ_DONE_OUT = done_reg;
    assign COLLISION_IRQ_FLAG_OUT = flag_reg;

    // checks on the sequencer
    rs_sda_low_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::RS_SCL_WAIT) && scl_s && !sda_s
        |=> COLLISION_IRQ_FLAG_OUT && !SDA_OE_OUT && !SCL_OE_OUT)
        else $error("sda low at scl rise not flagged");

    rs_scl_drop_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::RS_CNT2) && sda_s && !scl_s
        |=> COLLISION_IRQ_FLAG_OUT && !RSTART_ACTIVE_OUT)
        else $error("scl drop before sda low not flagged");

    rs_first_load_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::RS_REL_SDA) && sda_s
        |=> (bit_rate_counter_reg == $past(reload))
            && (state_reg == i2c_coll_pkg::RS_CNT1))
        else $error("counter not loaded once sda is high");

    rs_early_sda_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::RS_CNT2) && !sda_s
        |=> SDA_OE_OUT && RSTART_ACTIVE_OUT
            && !$rose(COLLISION_IRQ_FLAG_OUT))
        else $error("early sda fall treated as collision");

    rs_release_scl_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::RS_CNT1) && expired
        |=> !SCL_OE_OUT ##0 (state_reg == i2c_coll_pkg::RS_SCL_WAIT))
        else $error("scl not released at first expiry");

    rs_finish_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::RS_CNT3) && expired
        |=> SCL_OE_OUT && SDA_OE_OUT && SEQ_DONE_OUT
            && !RSTART_ACTIVE_OUT ##1 !SEQ_DONE_OUT)
        else $error("repeated start did not complete");

    sp_scl_load_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::SP_SCL_WAIT) && scl_s
        |=> (bit_rate_counter_reg == $past(reload)) && SDA_OE_OUT)
        else $error("stop counter not loaded on scl high");

    sp_sda_low_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::SP_CNT2) && expired && !sda_s
        |=> COLLISION_IRQ_FLAG_OUT && !STOP_ACTIVE_OUT && !SEQ_DONE_OUT)
        else $error("sda low after stop count not flagged");

    sp_scl_low_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::SP_CNT1) && !scl_s
        |=> COLLISION_IRQ_FLAG_OUT && !SCL_OE_OUT)
        else $error("scl low in stop not flagged");

    abort_release_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        coll_set |=> !SDA_OE_OUT && !SCL_OE_OUT && !RSTART_ACTIVE_OUT
            && !STOP_ACTIVE_OUT && (state_reg == i2c_coll_pkg::ST_IDLE))
        else $error("collision did not free the bus");

    flag_sticky_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        COLLISION_IRQ_FLAG_OUT && !COLLISION_CLEAR_IN
        |=> COLLISION_IRQ_FLAG_OUT)
        else $error("collision flag lost without clear");

    sync_gate_a: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == i2c_coll_pkg::SP_SDA_LOW) && sda_s
        |=> (state_reg == i2c_coll_pkg::SP_SDA_LOW) && SCL_OE_OUT)
        else $error("scl released before sda sampled low");

endmodule // i2c_rsen_stop_master

// *** test/bus_party.sv ***
`timescale 1ns/1ps
// the other masters and slaves on the wire, as open-drain pull-downs
module bus_party (
    // pull-downs of the design
    input wire logic sda_oe_in,
    input wire logic scl_oe_in,
    // pull-downs the bench commands for the far side
    input wire logic sda_pull_in,
    input wire logic scl_pull_in,
    // wired levels seen by every party
    output logic sda_line_out,
    output logic scl_line_out
);
    // wired-and with pull-ups: a released line reads high, never stale
    assign sda_line_out = ~(sda_oe_in | sda_pull_in);
    assign scl_line_out = ~(scl_oe_in | scl_pull_in);
endmodule // bus_party

// *** test/i2c_master_collision_rsen_stop_tb.sv ***
`timescale 1ns/1ps
module i2c_master_collision_rsen_stop_tb;
    // bit 7 set on purpose: only the low seven bits may count
    localparam logic [7:0] reload_val = 8'h94;
    localparam int n_cnt = 20;
    logic clk, link_clk, rst, rs_req, sp_req, clr, sda_pull, scl_pull;
    logic sda_line, scl_line, sda_oe, scl_oe, rs_act, sp_act, done, flag;
    logic sda_drv, scl_drv;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    i2c_rsen_stop_master i_dut (.CLK_IN(clk), .RST_IN(rst),
        .LINK_CLK_IN(link_clk), .SDA_IN(sda_line), .SDA_OUT(sda_drv),
        .SDA_OE_OUT(sda_oe), .SCL_IN(scl_line), .SCL_OUT(scl_drv),
        .SCL_OE_OUT(scl_oe), .RSTART_REQ_IN(rs_req), .STOP_REQ_IN(sp_req),
        .BAUD_RELOAD_VALUE_IN(reload_val), .RSTART_ACTIVE_OUT(rs_act),
        .STOP_ACTIVE_OUT(sp_act), .SEQ_DONE_OUT(done),
        .COLLISION_IRQ_FLAG_OUT(flag), .COLLISION_CLEAR_IN(clr));

    bus_party i_party (.sda_oe_in(sda_oe), .scl_oe_in(scl_oe),
        .sda_pull_in(sda_pull), .scl_pull_in(scl_pull),
        .sda_line_out(sda_line), .scl_line_out(scl_line));

    // system clock 50 ns, link clock 12 ns with an odd phase
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hung sequence would otherwise stall the run forever
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic cmp(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one-cycle request, stop always asked too so repeated start must win;
    // looked at right after the taking edge, since a stop on a bus already
    // held low lets scl go one edge later
    task automatic start(input logic rs);
        @(posedge clk);
        rs_req <= rs;
        sp_req <= 1'b1;
        @(posedge clk);
        rs_req <= 1'b0;
        sp_req <= 1'b0;
        #1;
        cmp(rs ? rs_act : sp_act, 1'b1);
        cmp(rs ? sp_act : rs_act, 1'b0);
        cmp(sda_oe, ~rs);
        cmp(scl_oe, 1'b1);
    endtask

    // bounded wait for the design to let go of a line
    task automatic wait_fall(input logic sel);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((sel ? scl_oe : sda_oe) !== 1'b0 && k < 200);
        cmp(sel ? scl_oe : sda_oe, 1'b0);
    endtask

    // outcome of a sequence, then free the bus and clear the flag
    task automatic check_end(input logic coll);
        cmp(flag, coll);
        cmp(sda_drv | scl_drv, 1'b0);
        cmp(rs_act, 1'b0);
        cmp(sp_act, 1'b0);
        if (coll) begin
            cmp(sda_oe, 1'b0);
            cmp(scl_oe, 1'b0);
        end
        @(posedge clk);
        sda_pull <= 1'b0;
        scl_pull <= 1'b0;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        #1;
        cmp(flag, 1'b0);
        tick(8);
    endtask

    task automatic finish_seq(input logic coll);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (done !== 1'b1 && flag !== 1'b1 && k < 300);
        cmp(done | flag, 1'b1);
        check_end(coll);
    endtask

    // far side stretches the clock for a while: arbitration, no collision
    task automatic rstart_ok();
        start(1'b1);
        @(posedge clk);
        scl_pull <= 1'b1;
        wait_fall(1'b1);
        tick(6);
        scl_pull <= 1'b0;
        finish_seq(1'b0);
        cmp(sda_oe, 1'b1);
        cmp(scl_oe, 1'b1);
    endtask

    // stop from a held bus; sda release to completion is one full count
    task automatic stop_ok();
        int n;
        start(1'b0);
        wait_fall(1'b1);
        cmp(sda_oe, 1'b1);
        wait_fall(1'b0);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 100);
        cmp(n >= n_cnt + 1 && n <= n_cnt + 2, 1'b1);
        check_end(1'b0);
    endtask

    // another master holds sda low as scl rises; pulled during the first
    // count so both lines settle well apart in the synchronisers
    task automatic rs_sda_coll();
        start(1'b1);
        tick(8);
        sda_pull <= 1'b1;
        wait_fall(1'b1);
        finish_seq(1'b1);
    endtask

    // sda falls early in the second count: no collision
    task automatic rs_early_sda();
        start(1'b1);
        wait_fall(1'b1);
        tick(10);
        sda_pull <= 1'b1;
        finish_seq(1'b0);
    endtask

    // scl pulled low in the second count while sda is still high
    task automatic rs_scl_coll();
        start(1'b1);
        wait_fall(1'b1);
        tick(10);
        scl_pull <= 1'b1;
        finish_seq(1'b1);
    endtask

    // sda held low past the count after its release
    task automatic sp_sda_coll();
        start(1'b0);
        wait_fall(1'b0);
        sda_pull <= 1'b1;
        finish_seq(1'b1);
    endtask

    // sda kept low by the far side, scl pulled low in the second count:
    // must be flagged early, not only at expiry
    task automatic sp_late_coll();
        int n;
        start(1'b0);
        wait_fall(1'b1);
        @(posedge clk);
        sda_pull <= 1'b1;
        wait_fall(1'b0);
        @(posedge clk);
        scl_pull <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (flag !== 1'b1 && n < 100);
        cmp(n < n_cnt, 1'b1);
        check_end(1'b1);
    endtask

    // scl pulled low before sda has gone high
    task automatic sp_scl_coll();
        start(1'b0);
        wait_fall(1'b1);
        tick(10);
        scl_pull <= 1'b1;
        finish_seq(1'b1);
    endtask

    initial begin
        rst = 1'b1;
        rs_req = 1'b0;
        sp_req = 1'b0;
        clr = 1'b0;
        sda_pull = 1'b0;
        scl_pull = 1'b0;
        tick(5);
        rst <= 1'b0;
        tick(8);
        rstart_ok();
        stop_ok();
        rs_sda_coll();
        rs_early_sda();
        rs_scl_coll();
        sp_sda_coll();
        sp_scl_coll();
        sp_late_coll();
        give_verdict();
    end
endmodule // i2c_master_collision_rsen_stop_tb
